// >>> rtl/qpv_pkg.sv
// Package for the quadrature position and velocity block.
// Assumes a single system clock; all configuration arrives as plain ports.
package qpv_pkg;
   localparam int POS_W        = 32;
   localparam int VEL_W        = 32;
   localparam int WIN_W        = 32;
   localparam int PREDIV_W     = 3;
   localparam int EVT_W        = 4;
   // Event bit positions
   localparam int EVT_ERR_BIT  = 0;
   localparam int EVT_DIR_BIT  = 1;
   localparam int EVT_TMR_BIT  = 2;
   localparam int EVT_IDX_BIT  = 3;
   // Reset values
   localparam logic [31:0] POS_RST = 32'h0000_0000;
   localparam logic [31:0] VEL_RST = 32'h0000_0000;
   localparam logic [31:0] MAX_RST = 32'hFFFF_FFFF;
   localparam logic [3:0]  EVT_RST = 4'h0;

   typedef struct packed {
      logic capture_both;   // Count edges on both phases
      logic index_reload;   // Reload position on index
      logic clock_dir;      // Clock plus direction decoding
      logic swap;           // Swap phase inputs
   } qpv_cfg_t;

   typedef struct packed {
      logic step;           // One counted edge
      logic fwd;            // Direction of that edge
      logic err;            // Both phases changed together
      logic index;          // Index rising edge
   } qpv_step_t;
endpackage

// >>> rtl/qpv_decode.sv
// Phase decoder: turns sampled phase and index pins into step events.
// Assumes inputs are synchronous to ref_clk_in.
`timescale 1ns/100ps
module qpv_decode (
   // Clock and reset
   input  wire logic             ref_clk_in,
   input  wire logic             reset_in,
   // Pins and configuration
   input  wire logic             phase_a_input_in,
   input  wire logic             phase_b_input_in,
   input  wire logic             index_in,
   input  wire qpv_pkg::qpv_cfg_t cfg_in,
   // Step events
   output qpv_pkg::qpv_step_t    step_out
);
   typedef struct packed {
      logic               a;
      logic               b;
      logic               idx;
      logic               primed;
      qpv_pkg::qpv_step_t st;
   } qpv_dec_state_t;

   qpv_dec_state_t s_q;
   qpv_dec_state_t s_d;
   logic           a;
   logic           b;
   logic           ach;
   logic           bch;

   always_comb begin
      a   = cfg_in.swap ? phase_b_input_in : phase_a_input_in;
      b   = cfg_in.swap ? phase_a_input_in : phase_b_input_in;
      ach = a ^ s_q.a;
      bch = b ^ s_q.b;
      s_d       = s_q;
      s_d.a     = a;
      s_d.b     = b;
      s_d.idx   = index_in;
      s_d.st    = '0;
      s_d.st.index = index_in & ~s_q.idx;
      if (cfg_in.clock_dir) begin
         // Rising edge of A is the clock, B is direction
         s_d.st.step = ach & a;
         s_d.st.fwd  = ~b;
      end else begin
         s_d.st.err  = ach & bch;
         if (ach & ~bch) begin
            s_d.st.step = 1'b1;
            s_d.st.fwd  = a ^ b;
         end else if (bch & ~ach & cfg_in.capture_both) begin
            s_d.st.step = 1'b1;
            s_d.st.fwd  = ~(a ^ b);
         end
      end
      s_d.primed = 1'b1;
      if (!s_q.primed) begin
         // First sample after reset only seeds the pin history
         s_d.st = '0;
      end
   end

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign step_out = s_q.st;
endmodule // qpv_decode

// >>> rtl/qpv_velocity.sv
// Velocity capture: predivides steps, counts them over a clock window.
// Assumes window length nonzero and set before enabling.
`timescale 1ns/100ps
module qpv_velocity #(
   parameter int VEL_W = qpv_pkg::VEL_W,
   parameter int WIN_W = qpv_pkg::WIN_W
) (
   // Clock and reset
   input  wire logic                 ref_clk_in,
   input  wire logic                 reset_in,
   // Control
   input  wire logic                 run_in,
   input  wire logic                 step_in,
   input  wire logic [2:0]           prediv_in,
   input  wire logic [WIN_W-1:0]     window_in,
   // Results
   output logic [VEL_W-1:0]          velocity_out,
   output logic                      window_done_out
);
   typedef struct packed {
      logic [6:0]       pre;
      logic [VEL_W-1:0] acc;
      logic [WIN_W-1:0] tmr;
      logic [VEL_W-1:0] vel;
      logic             done;
   } qpv_vel_state_t;

   qpv_vel_state_t s_q;
   qpv_vel_state_t s_d;
   logic [6:0]     lim;
   logic           div_pulse;

   always_comb begin
      lim       = 7'((8'h01 << prediv_in) - 8'h01);
      div_pulse = step_in && (s_q.pre >= lim);
      s_d       = s_q;
      s_d.done  = 1'b0;
      if (!run_in) begin
         // Hold result, restart window on next enable
         s_d.pre = '0;
         s_d.acc = '0;
         s_d.tmr = '0;
      end else begin
         if (step_in) begin
            s_d.pre = div_pulse ? 7'h00 : 7'(s_q.pre + 7'h01);
         end
         if (s_q.tmr >= window_in - WIN_W'(1)) begin
            s_d.vel  = s_q.acc + VEL_W'(div_pulse);
            s_d.acc  = '0;
            s_d.tmr  = '0;
            s_d.done = 1'b1;
         end else begin
            s_d.acc = s_q.acc + VEL_W'(div_pulse);
            s_d.tmr = s_q.tmr + WIN_W'(1);
         end
      end
   end

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign velocity_out    = s_q.vel;
   assign window_done_out = s_q.done;
endmodule // qpv_velocity

// >>> rtl/qpv_top.sv
// Top of the quadrature position and velocity block.
// Assumes plain-port software control, synchronous pins, one 25 MHz clock.
`timescale 1ns/100ps
module qpv_top #(
   parameter int POS_W = qpv_pkg::POS_W,
   parameter int VEL_W = qpv_pkg::VEL_W,
   parameter int WIN_W = qpv_pkg::WIN_W
) (
   // Clock and reset
   input  wire logic                 ref_clk_in,
   input  wire logic                 reset_in,
   // Encoder pins
   input  wire logic                 phase_a_input_in,
   input  wire logic                 phase_b_input_in,
   input  wire logic                 index_in,
   // Configuration
   input  wire logic                 enable_in,
   input  wire logic                 velocity_enable_in,
   input  wire qpv_pkg::qpv_cfg_t    cfg_in,
   input  wire logic [POS_W-1:0]     max_position_in,
   input  wire logic [2:0]           velocity_prediv_select_in,
   input  wire logic [WIN_W-1:0]     window_in,
   // Position load
   input  wire logic                 position_load_in,
   input  wire logic [POS_W-1:0]     position_value_in,
   // Events
   input  wire logic [3:0]           event_enable_in,
   input  wire logic [3:0]           event_clear_in,
   input  wire logic                 status_masked_in,
   // Results
   output logic [POS_W-1:0]          position_out,
   output logic [VEL_W-1:0]          velocity_out,
   output logic                      direction_out,
   output logic                      phase_error_out,
   output logic                      index_aligned_out,
   output logic [3:0]                event_status_out,
   output logic                      irq_out
);
   typedef struct packed {
      logic [POS_W-1:0] pos;
      logic             dir;
      logic             err;
      logic             aligned;
      logic [3:0]       evt;
      logic [3:0]       status;
      logic             irq;
   } qpv_top_state_t;

   qpv_top_state_t     s_q;
   qpv_top_state_t     s_d;
   qpv_pkg::qpv_step_t st;
   logic               win_done;
   logic [3:0]         set;

   qpv_decode u_decode (
      .ref_clk_in       (ref_clk_in),
      .reset_in         (reset_in),
      .phase_a_input_in (phase_a_input_in),
      .phase_b_input_in (phase_b_input_in),
      .index_in         (index_in),
      .cfg_in           (cfg_in),
      .step_out         (st)
   );

   qpv_velocity #(
      .VEL_W (VEL_W),
      .WIN_W (WIN_W)
   ) u_velocity (
      .ref_clk_in      (ref_clk_in),
      .reset_in        (reset_in),
      .run_in          (enable_in & velocity_enable_in),
      .step_in         (st.step),
      .prediv_in       (velocity_prediv_select_in),
      .window_in       (window_in),
      .velocity_out    (velocity_out),
      .window_done_out (win_done)
   );

   always_comb begin
      s_d = s_q;
      set = '0;
      if (enable_in) begin
         set[qpv_pkg::EVT_ERR_BIT] = st.err;
         set[qpv_pkg::EVT_IDX_BIT] = st.index;
         if (st.err) begin
            s_d.err = 1'b1;
         end
         if (st.step) begin
            s_d.dir = st.fwd;
            set[qpv_pkg::EVT_DIR_BIT] = st.fwd ^ s_q.dir;
            if (st.fwd) begin
               s_d.pos = (s_q.pos >= max_position_in) ? '0
                                                      : s_q.pos + POS_W'(1);
            end else begin
               s_d.pos = (s_q.pos == '0) ? max_position_in
                                         : s_q.pos - POS_W'(1);
            end
         end
         if (st.index && cfg_in.index_reload) begin
            s_d.pos     = s_d.dir ? '0 : max_position_in;
            s_d.aligned = 1'b1;
         end
      end
      set[qpv_pkg::EVT_TMR_BIT] = win_done;
      if (position_load_in) begin
         s_d.pos = position_value_in;
      end
      // Set wins over clear in the same cycle
      s_d.evt    = (s_q.evt & ~event_clear_in) | set;
      s_d.status = status_masked_in ? (s_q.evt & event_enable_in) : s_q.evt;
      s_d.irq    = |(s_d.evt & event_enable_in);
   end

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         s_q         <= '0;
         s_q.pos     <= qpv_pkg::POS_RST[POS_W-1:0];
         s_q.dir     <= 1'b1;
         s_q.evt     <= qpv_pkg::EVT_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign position_out      = s_q.pos;
   assign direction_out     = s_q.dir;
   assign phase_error_out   = s_q.err;
   assign index_aligned_out = s_q.aligned;
   assign event_status_out  = s_q.status;
   assign irq_out           = s_q.irq;
endmodule // qpv_top

// >>> test/qpv_top_chk.sv
// Checker for the quadrature block, bound to the top module.
// Assumes it sees only the top ports and one clock domain.
`timescale 1ns/100ps
module qpv_top_chk #(
   parameter int POS_W = qpv_pkg::POS_W,
   parameter int VEL_W = qpv_pkg::VEL_W,
   parameter int WIN_W = qpv_pkg::WIN_W
) (
   // Clock, reset, pins
   input wire logic              ref_clk_in,
   input wire logic              reset_in,
   input wire logic              phase_a_input_in,
   input wire logic              phase_b_input_in,
   input wire logic              index_in,
   // Controls
   input wire logic              enable_in,
   input wire logic              velocity_enable_in,
   input wire qpv_pkg::qpv_cfg_t cfg_in,
   input wire logic              position_load_in,
   input wire logic [POS_W-1:0]  position_value_in,
   input wire logic [3:0]        event_enable_in,
   input wire logic              status_masked_in,
   // Results
   input wire logic [POS_W-1:0]  position_out,
   input wire logic [VEL_W-1:0]  velocity_out,
   input wire logic              phase_error_out,
   input wire logic              index_aligned_out,
   input wire logic [3:0]        event_status_out,
   input wire logic              irq_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);
   property p_irq;
      (event_enable_in == 4'h0)[*3] |=> !irq_out;
   endproperty
   a_irq: assert property (p_irq) else $error("irq with all sources off");
   property p_load;
      position_load_in |=> position_out == $past(position_value_in);
   endproperty
   a_load: assert property (p_load) else $error("position load missed");
   property p_main;
      (!enable_in)[*3] |=> $stable(velocity_out);
   endproperty
   a_main: assert property (p_main) else $error("velocity moved while off");
   property p_vel;
      (!velocity_enable_in)[*3] |=> $stable(velocity_out);
   endproperty
   a_vel: assert property (p_vel) else $error("velocity moved while stopped");
   property p_err;
      enable_in && !cfg_in.clock_dir && $changed(phase_a_input_in) &&
         $changed(phase_b_input_in) |-> ##[1:3] phase_error_out;
   endproperty
   a_err: assert property (p_err) else $error("phase error not flagged");
   property p_mask;
      (status_masked_in && event_enable_in == 4'h0)[*3] |=> event_status_out == 4'h0;
   endproperty
   a_mask: assert property (p_mask) else $error("masked status not gated");
   property p_algn;
      index_aligned_out |=> index_aligned_out;
   endproperty
   a_algn: assert property (p_algn) else $error("alignment lost");
   property p_hold;
      (!position_load_in && !index_in && $stable(phase_a_input_in) &&
         $stable(phase_b_input_in))[*3] |=> $stable(position_out);
   endproperty
   a_hold: assert property (p_hold) else $error("position moved without edge");
endmodule // qpv_top_chk

// >>> test/qpv_enc_model.sv
// Encoder model: gray-coded phases, glitch and index on command.
// Assumes commands change at the falling edge; phases follow one edge later, index at once.
`timescale 1ns/100ps
module qpv_enc_model (
   // Clock and commands
   input  wire logic clk_in,
   input  wire logic fwd_in,
   input  wire logic rev_in,
   input  wire logic glitch_in,
   input  wire logic idx_in,
   // Pins
   output logic      phase_a_out,
   output logic      phase_b_out,
   output logic      index_out
);
   logic [1:0] ph_q = 2'h0;
   logic       g_q  = 1'b0;
   always @(negedge clk_in) begin
      ph_q <= ph_q + {rev_in, fwd_in | rev_in};
      g_q  <= g_q ^ glitch_in;
   end
   assign phase_a_out = ph_q[0] ^ ph_q[1] ^ g_q;
   assign phase_b_out = ph_q[1] ^ g_q;
   assign index_out   = idx_in;
endmodule // qpv_enc_model

// >>> test/testbench.sv
// Self-checking bench for the quadrature block with an encoder model.
// Assumes design, model and checker files are compiled first.
`timescale 1ns/100ps
module testbench;
   logic              clk = 1'b0, rst = 1'b1, fwd = 1'b0, rev = 1'b0;
   logic              glt = 1'b0, idx = 1'b0, en = 1'b0, ven = 1'b0;
   logic              ld = 1'b0, msk = 1'b0, pa, pb, pi, dir, perr, algn, irq;
   qpv_pkg::qpv_cfg_t cfg = 4'h0;
   logic [31:0]       mx = 32'hFFFF_FFFF, win = 32'h0000_0080, pv = 32'h0, pos, vel;
   logic [2:0]        pdv = 3'h0;
   logic [3:0]        emask = 4'h0, eclr = 4'h0, est;
   int                err_total = 0, tests_run = 0, cyc = 0;
   initial forever #20 clk = ~clk;
   qpv_enc_model qpv_enc_model_i (.clk_in(clk), .fwd_in(fwd), .rev_in(rev),
      .glitch_in(glt), .idx_in(idx), .phase_a_out(pa), .phase_b_out(pb), .index_out(pi));
   qpv_top qpv_top_i (.ref_clk_in(clk), .reset_in(rst), .phase_a_input_in(pa),
      .phase_b_input_in(pb), .index_in(pi), .enable_in(en), .velocity_enable_in(ven),
      .cfg_in(cfg), .max_position_in(mx), .velocity_prediv_select_in(pdv), .window_in(win),
      .position_load_in(ld), .position_value_in(pv), .event_enable_in(emask),
      .event_clear_in(eclr), .status_masked_in(msk), .position_out(pos), .velocity_out(vel),
      .direction_out(dir), .phase_error_out(perr), .index_aligned_out(algn),
      .event_status_out(est), .irq_out(irq));
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic move(input logic f, input int n);
      fwd <= f;
      rev <= !f;
      repeat (n) @(negedge clk);
      fwd <= 1'b0;
      rev <= 1'b0;
      repeat (4) @(negedge clk);
   endtask
   task automatic load(input logic [31:0] v);
      ld <= 1'b1;
      pv <= v;
      @(negedge clk);
      ld <= 1'b0;
      repeat (2) @(negedge clk);
   endtask
   task automatic pin_pulse(input bit g);
      if (g) begin
         glt <= 1'b1;
      end else begin
         idx <= 1'b1;
      end
      @(negedge clk);
      glt <= 1'b0;
      idx <= 1'b0;
      repeat (5) @(negedge clk);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (10) @(negedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk("dir", 32'h1, dir);
      en  <= 1'b1;
      cfg <= 4'h8;
      move(1'b1, 4);
      chk("pos", 32'h4, pos);
      move(1'b0, 2);
      chk("pos", 32'h2, pos);
      chk("dir", 32'h0, dir);
      cfg <= 4'h0;
      move(1'b1, 4);
      chk("pos", 32'h4, pos);
      load(32'h0000_0064);
      move(1'b1, 1);
      chk("pos", 32'h65, pos);
      mx <= 32'h5;
      cfg <= 4'h8;
      load(32'h5);
      move(1'b1, 1);
      chk("pos", 32'h0, pos);
      move(1'b0, 1);
      chk("pos", 32'h5, pos);
      cfg <= 4'h2;
      load(32'h0);
      move(1'b1, 4);
      chk("pos", 32'h1, pos);
      move(1'b0, 4);
      chk("pos", 32'h0, pos);
      cfg <= 4'h9;
      move(1'b1, 4);
      chk("pos", 32'h2, pos);
      cfg <= 4'hC;
      chk("aligned", 32'h0, algn);
      pin_pulse(1'b0);
      chk("pos", 32'h5, pos);
      chk("aligned", 32'h1, algn);
      chk("index evt", 32'h1, est[3]);
      move(1'b1, 2);
      pin_pulse(1'b0);
      chk("pos", 32'h0, pos);
      eclr  <= 4'hF;
      @(negedge clk);
      eclr  <= 4'h0;
      emask <= 4'h1;
      cfg   <= 4'h8;
      @(negedge clk);
      chk("events", 32'h0, est);
      // Mid-run reset: sticky error drops, pin history must not fake a step
      rst <= 1'b1;
      @(negedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk("perr", 32'h0, perr);
      pin_pulse(1'b1);
      chk("perr", 32'h1, perr);
      chk("pos", 32'h0, pos);
      chk("irq", 32'h1, irq);
      chk("err evt", 32'h1, est[0]);
      msk <= 1'b1;
      repeat (3) @(negedge clk);
      chk("masked", 32'h1, est);
      emask <= 4'h0;
      repeat (4) @(negedge clk);
      chk("masked", 32'h0, est);
      chk("irq", 32'h0, irq);
      msk <= 1'b0;
      repeat (3) @(negedge clk);
      chk("err evt", 32'h1, est[0]);
      eclr <= 4'h1;
      @(negedge clk);
      eclr <= 4'h0;
      repeat (3) @(negedge clk);
      chk("err evt", 32'h0, est[0]);
      mx    <= 32'hFFFF_FFFF;
      emask <= 4'h4;
      fwd   <= 1'b1;
      @(negedge clk);
      ven <= 1'b1;
      for (int n = 0; n < 8; n++) begin
         pdv <= n[2:0];
         repeat (392) @(negedge clk);
         chk("vel", 32'h80 >> n, vel);
      end
      chk("irq", 32'h1, irq);
      chk("timer evt", 32'h1, est[2]);
      ven <= 1'b0;
      pdv <= 3'h0;
      repeat (300) @(negedge clk);
      pv = pos;
      repeat (10) @(negedge clk);
      chk("pos", pv + 32'hA, pos);
      chk("vel", 32'h1, vel);
      ven <= 1'b1;
      en  <= 1'b0;
      pdv <= 3'h0;
      repeat (300) @(negedge clk);
      chk("vel", 32'h1, vel);
      tally_and_finish();
   end
endmodule // testbench
bind qpv_top qpv_top_chk #(.POS_W(POS_W), .VEL_W(VEL_W), .WIN_W(WIN_W)) chk_i (
   .ref_clk_in, .reset_in, .phase_a_input_in, .phase_b_input_in, .index_in, .enable_in,
   .velocity_enable_in, .cfg_in, .position_load_in, .position_value_in, .event_enable_in,
   .status_masked_in, .position_out, .velocity_out, .phase_error_out, .index_aligned_out,
   .event_status_out, .irq_out);
